// >>> hw/aru_consts.vh
`ifndef ARU_CONSTS_VH
`define ARU_CONSTS_VH

// ------------------------------------------------------------------
// Widths and bit positions
// ------------------------------------------------------------------
`define ARU_W          16
`define ARU_MSB        15
`define ARU_LSB        0
`define ARU_SEL_W      4

// ------------------------------------------------------------------
// Full 16-bit instruction encodings
// ------------------------------------------------------------------
`define ARU_ENC_RLP    16'h8A4A
`define ARU_ENC_RLC    16'h8A5A
`define ARU_ENC_RRP    16'h8ACA
`define ARU_ENC_RRC    16'h8ADA

// ------------------------------------------------------------------
// Internal operation codes
// ------------------------------------------------------------------
`define ARU_OP_W       2
`define ARU_OP_RLP     2'h0
`define ARU_OP_RLC     2'h1
`define ARU_OP_RRP     2'h2
`define ARU_OP_RRC     2'h3

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define ARU_ACC_RST    16'h0000
`define ARU_SEL_RST    4'h0
`define ARU_BIT_RST    1'b0

`endif

// >>> hw/aru_rotate_core.v
`timescale 1ns/1ps
`include "aru_consts.vh"

// Single-position rotate and flag derivation, purely combinational.
module aru_rotate_core
(
   input  wire [`ARU_OP_W-1:0] opSel,
   input  wire [`ARU_W-1:0]    accSrc,
   input  wire                 carrySrc,
   output reg  [`ARU_W-1:0]    result,
   output reg                  carryNew,
   output wire                 signNew,
   output wire                 zeroNew
);

   // ------------------------------------------------------------------
   // Rotate by exactly one place
   // ------------------------------------------------------------------
   // Carry passes through unchanged for the plain forms
   always @*
   begin
      result   = accSrc;
      carryNew = carrySrc;
      case (opSel)
         `ARU_OP_RLP:
         begin
            result = {accSrc[`ARU_MSB-1:`ARU_LSB], accSrc[`ARU_MSB]};   // RULE_01 RULE_07
         end
         `ARU_OP_RLC:
         begin
            result   = {accSrc[`ARU_MSB-1:`ARU_LSB], carrySrc};         // RULE_02 RULE_07
            carryNew = accSrc[`ARU_MSB];                                 // RULE_02
         end
         `ARU_OP_RRP:
         begin
            result = {accSrc[`ARU_LSB], accSrc[`ARU_MSB:`ARU_LSB+1]};   // RULE_03 RULE_08
         end
         `ARU_OP_RRC:
         begin
            result   = {carrySrc, accSrc[`ARU_MSB:`ARU_LSB+1]};         // RULE_04 RULE_08
            carryNew = accSrc[`ARU_LSB];                                 // RULE_04
         end
         default:
         begin
            result   = accSrc;
            carryNew = carrySrc;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // Sign and zero from the new value
   // ------------------------------------------------------------------
   assign signNew = result[`ARU_MSB];             // RULE_09
   assign zeroNew = (result == `ARU_ACC_RST);     // RULE_09

endmodule // aru_rotate_core

// >>> hw/aru_rotate_unit.v
// Summary of operation
// RULE_01: Plain left rotate: bit 15 wraps to bit 0.
// RULE_02: Left through carry: carry in, bit 15 out.
// RULE_03: Plain right rotate: bit 0 wraps to 15.
// RULE_04: Right through carry: carry in, bit 0 out.
// RULE_05: Left rotates set sign; carry/zero only through-carry.
// RULE_06: Right rotates set sign; carry/zero only through-carry.
// RULE_07: Each left rotate moves exactly one place.
// RULE_08: Each right rotate moves exactly one place.
// RULE_09: Sign is new bit 15; zero on result zero.
`timescale 1ns/1ps
`include "aru_consts.vh"

module aru_rotate_unit
(
   mclk,
   rst_n,
   instrValid,
   instrWord,
   accSel,
   accRdData,
   carryFlag,
   accWrEn,
   accWrSel,
   accWrData,
   carryWrEn,
   carryWrData,
   signWrEn,
   signWrData,
   zeroWrEn,
   zeroWrData,
   execDone
);

   // ------------------------------------------------------------------
   // Ports
   // ------------------------------------------------------------------
   input  wire                  mclk;
   input  wire                  rst_n;
   input  wire                  instrValid;
   input  wire [`ARU_W-1:0]     instrWord;
   input  wire [`ARU_SEL_W-1:0] accSel;
   input  wire [`ARU_W-1:0]     accRdData;
   input  wire                  carryFlag;
   output wire                  accWrEn;
   output wire [`ARU_SEL_W-1:0] accWrSel;
   output wire [`ARU_W-1:0]     accWrData;
   output wire                  carryWrEn;
   output wire                  carryWrData;
   output wire                  signWrEn;
   output wire                  signWrData;
   output wire                  zeroWrEn;
   output wire                  zeroWrData;
   output wire                  execDone;

   // ------------------------------------------------------------------
   // Registers and next values
   // ------------------------------------------------------------------
   reg                  accWrEn_reg;
   reg                  accWrEn_next;
   reg [`ARU_SEL_W-1:0] accWrSel_reg;
   reg [`ARU_SEL_W-1:0] accWrSel_next;
   reg [`ARU_W-1:0]     accWrData_reg;
   reg [`ARU_W-1:0]     accWrData_next;
   reg                  carryWrEn_reg;
   reg                  carryWrEn_next;
   reg                  carryWrData_reg;
   reg                  carryWrData_next;
   reg                  signWrEn_reg;
   reg                  signWrEn_next;
   reg                  signWrData_reg;
   reg                  signWrData_next;
   reg                  zeroWrEn_reg;
   reg                  zeroWrEn_next;
   reg                  zeroWrData_reg;
   reg                  zeroWrData_next;

   // ------------------------------------------------------------------
   // Decode and operand wires
   // ------------------------------------------------------------------
   reg                  opHit;
   reg [`ARU_OP_W-1:0]  opSel;
   reg                  throughCarry;
   wire                 fwdAcc;
   wire [`ARU_W-1:0]    accSrc;
   wire                 carrySrc;
   wire [`ARU_W-1:0]    rotResult;
   wire                 rotCarry;
   wire                 rotSign;
   wire                 rotZero;

   // ------------------------------------------------------------------
   // Instruction decode
   // ------------------------------------------------------------------
   // Full-word match; any other word is left for other slices
   always @*
   begin
      opHit        = 1'b1;
      opSel        = `ARU_OP_RLP;
      throughCarry = 1'b0;
      case (instrWord)
         `ARU_ENC_RLP:
         begin
            opSel = `ARU_OP_RLP;                       // RULE_01
         end
         `ARU_ENC_RLC:
         begin
            opSel        = `ARU_OP_RLC;                // RULE_02
            throughCarry = 1'b1;
         end
         `ARU_ENC_RRP:
         begin
            opSel = `ARU_OP_RRP;                       // RULE_03
         end
         `ARU_ENC_RRC:
         begin
            opSel        = `ARU_OP_RRC;                // RULE_04
            throughCarry = 1'b1;
         end
         default:
         begin
            opHit = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // Operand forwarding
   // ------------------------------------------------------------------
   // The accumulator file and flag register take our result one edge
   // after we present it, so a back-to-back rotate would otherwise read
   // the stale value and the pair would move the word only once.
   // Forwarding keeps every execution worth exactly one place.
   assign fwdAcc   = accWrEn_reg && (accWrSel_reg == accSel);           // RULE_07 RULE_08
   assign accSrc   = fwdAcc ? accWrData_reg : accRdData;                // RULE_07 RULE_08
   assign carrySrc = carryWrEn_reg ? carryWrData_reg : carryFlag;       // RULE_02 RULE_04

   // ------------------------------------------------------------------
   // Rotate datapath
   // ------------------------------------------------------------------
   aru_rotate_core uCore
   (
      .opSel    (opSel),
      .accSrc   (accSrc),
      .carrySrc (carrySrc),
      .result   (rotResult),
      .carryNew (rotCarry),
      .signNew  (rotSign),
      .zeroNew  (rotZero)
   );

   // ------------------------------------------------------------------
   // Next-state of the write-back stage
   // ------------------------------------------------------------------
   // Enables are one-cycle pulses; data holds between executions so a
   // late sampler still sees the last result.
   always @*
   begin
      accWrEn_next     = 1'b0;
      accWrSel_next    = accWrSel_reg;
      accWrData_next   = accWrData_reg;
      carryWrEn_next   = 1'b0;
      carryWrData_next = carryWrData_reg;
      signWrEn_next    = 1'b0;
      signWrData_next  = signWrData_reg;
      zeroWrEn_next    = 1'b0;
      zeroWrData_next  = zeroWrData_reg;
      if (instrValid && opHit)
      begin
         accWrEn_next    = 1'b1;                               // RULE_07 RULE_08
         accWrSel_next   = accSel;
         accWrData_next  = rotResult;
         signWrEn_next   = 1'b1;                               // RULE_05 RULE_06
         signWrData_next = rotSign;                            // RULE_09
         // Plain forms leave carry and zero alone
         if (throughCarry)
         begin
            carryWrEn_next   = 1'b1;                           // RULE_05 RULE_06
            carryWrData_next = rotCarry;
            zeroWrEn_next    = 1'b1;                           // RULE_05 RULE_06
            zeroWrData_next  = rotZero;                        // RULE_09
         end
      end
   end

   // ------------------------------------------------------------------
   // Write-back registers
   // ------------------------------------------------------------------
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         accWrEn_reg     <= `ARU_BIT_RST;
         accWrSel_reg    <= `ARU_SEL_RST;
         accWrData_reg   <= `ARU_ACC_RST;
         carryWrEn_reg   <= `ARU_BIT_RST;
         carryWrData_reg <= `ARU_BIT_RST;
         signWrEn_reg    <= `ARU_BIT_RST;
         signWrData_reg  <= `ARU_BIT_RST;
         zeroWrEn_reg    <= `ARU_BIT_RST;
         zeroWrData_reg  <= `ARU_BIT_RST;
      end
      else
      begin
         accWrEn_reg     <= accWrEn_next;
         accWrSel_reg    <= accWrSel_next;
         accWrData_reg   <= accWrData_next;
         carryWrEn_reg   <= carryWrEn_next;
         carryWrData_reg <= carryWrData_next;
         signWrEn_reg    <= signWrEn_next;
         signWrData_reg  <= signWrData_next;
         zeroWrEn_reg    <= zeroWrEn_next;
         zeroWrData_reg  <= zeroWrData_next;
      end
   end

   // ------------------------------------------------------------------
   // Outputs, all straight from flip-flops
   // ------------------------------------------------------------------
   assign accWrEn     = accWrEn_reg;
   assign accWrSel    = accWrSel_reg;
   assign accWrData   = accWrData_reg;
   assign carryWrEn   = carryWrEn_reg;
   assign carryWrData = carryWrData_reg;
   assign signWrEn    = signWrEn_reg;
   assign signWrData  = signWrData_reg;
   assign zeroWrEn    = zeroWrEn_reg;
   assign zeroWrData  = zeroWrData_reg;
   assign execDone    = accWrEn_reg;   // Same flop: completion equals write

endmodule // aru_rotate_unit

// >>> test/aru_rotate_unit_properties.sv
`timescale 1ns/1ps
`include "aru_consts.vh"

// Port checks; data checks skip pulse cycles where forwarding hides inputs
module aru_rotate_unit_properties
(
   input wire        mclk,
   input wire        rst_n,
   input wire        instrValid,
   input wire [15:0] instrWord,
   input wire [3:0]  accSel,
   input wire [15:0] accRdData,
   input wire        carryFlag,
   input wire        accWrEn,
   input wire [3:0]  accWrSel,
   input wire [15:0] accWrData,
   input wire        carryWrEn,
   input wire        carryWrData,
   input wire        signWrEn,
   input wire        signWrData,
   input wire        zeroWrEn,
   input wire        zeroWrData,
   input wire        execDone
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // ------------------------------------------------------------
   // Issue and clean-input steps
   // ------------------------------------------------------------
   sequence s_issue(logic [15:0] enc); instrValid && instrWord == enc; endsequence
   sequence s_clean; !accWrEn; endsequence
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   property p_rlp_en;
      s_issue(`ARU_ENC_RLP) |=> accWrEn && signWrEn && !carryWrEn && !zeroWrEn;
   endproperty
   a_rlp_en: assert property (p_rlp_en) else $error("plain left enables wrong");
   property p_rlc_en;
      s_issue(`ARU_ENC_RLC) |=> accWrEn && signWrEn && carryWrEn && zeroWrEn;
   endproperty
   a_rlc_en: assert property (p_rlc_en) else $error("carry left enables wrong");
   property p_rrp_en;
      s_issue(`ARU_ENC_RRP) |=> accWrEn && signWrEn && !carryWrEn && !zeroWrEn;
   endproperty
   a_rrp_en: assert property (p_rrp_en) else $error("plain right enables wrong");
   property p_rrc_en;
      s_issue(`ARU_ENC_RRC) |=> accWrEn && signWrEn && carryWrEn && zeroWrEn;
   endproperty
   a_rrc_en: assert property (p_rrc_en) else $error("carry right enables wrong");
   property p_rlp_data;
      s_issue(`ARU_ENC_RLP) ##0 s_clean |=>
         accWrData == {$past(accRdData[14:0]), $past(accRdData[15])};
   endproperty
   a_rlp_data: assert property (p_rlp_data) else $error("plain left data bad");
   property p_rlc_data;
      s_issue(`ARU_ENC_RLC) ##0 s_clean |=> accWrData == {$past(accRdData[14:0]), $past(carryFlag)}
         && carryWrData == $past(accRdData[15]);
   endproperty
   a_rlc_data: assert property (p_rlc_data) else $error("carry left data bad");
   property p_rrp_data;
      s_issue(`ARU_ENC_RRP) ##0 s_clean |=>
         accWrData == {$past(accRdData[0]), $past(accRdData[15:1])};
   endproperty
   a_rrp_data: assert property (p_rrp_data) else $error("plain right data bad");
   property p_rrc_data;
      s_issue(`ARU_ENC_RRC) ##0 s_clean |=> accWrData == {$past(carryFlag), $past(accRdData[15:1])}
         && carryWrData == $past(accRdData[0]);
   endproperty
   a_rrc_data: assert property (p_rrc_data) else $error("carry right data bad");
   property p_flags;
      signWrEn |-> signWrData == accWrData[15]
         && (!zeroWrEn || zeroWrData == (accWrData == 16'h0000));
   endproperty
   a_flags: assert property (p_flags) else $error("sign or zero value wrong");
   property p_idle; !instrValid |=> !accWrEn && !execDone && !signWrEn && !carryWrEn; endproperty
   a_idle: assert property (p_idle) else $error("write without instruction");
   property p_sel; accWrEn |-> execDone && accWrSel == $past(accSel); endproperty
   a_sel: assert property (p_sel) else $error("write target wrong");
endmodule // aru_rotate_unit_properties

// >>> test/aru_rotate_unit_tb.sv
`timescale 1ns/1ps
`include "aru_consts.vh"

module aru_rotate_unit_tb;
   reg         mclk, rst_n, instrValid, carryFlag, fileC, stageC, modelC, cNew;
   reg  [15:0] instrWord, accRdData, lfsrState, aOld, rNew, expData;
   reg  [3:0]  accSel, expSel;
   reg         expEn, expCz, expC, expS, expZ;
   reg  [15:0] fileAcc [0:15];
   reg  [15:0] stageAcc [0:15];
   reg  [15:0] modelAcc [0:15];
   reg  [15:0] encTab [0:4];
   wire [15:0] accWrData;
   wire [3:0]  accWrSel;
   wire        accWrEn, carryWrEn, carryWrData, signWrEn, signWrData, zeroWrEn, zeroWrData;
   wire        execDone;
   integer     mismatches, num_checks, i, k, op;

   aru_rotate_unit u_dut (.mclk(mclk), .rst_n(rst_n), .instrValid(instrValid),
      .instrWord(instrWord), .accSel(accSel), .accRdData(accRdData), .carryFlag(carryFlag),
      .accWrEn(accWrEn), .accWrSel(accWrSel), .accWrData(accWrData), .carryWrEn(carryWrEn),
      .carryWrData(carryWrData), .signWrEn(signWrEn), .signWrData(signWrData),
      .zeroWrEn(zeroWrEn), .zeroWrData(zeroWrData), .execDone(execDone));

   // Fixed-seed pattern source
   function [15:0] lfsr_next(input [15:0] s);
      lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task check(input [8*8-1:0] name, input [22:0] expV, input [22:0] gotV);
   begin
      num_checks = num_checks + 1;
      if (gotV !== expV)
      begin
         mismatches = mismatches + 1;
         $display("[ERR] %0s expected %h seen %h", name, expV, gotV);
      end
   end
   endtask

   task final_report;
   begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   end
   endtask

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Accumulator file lags the model by one instruction, as the write-back does
   initial
   begin
      rst_n = 1'b0;
      instrValid = 1'b0;
      instrWord = 16'h0000;
      accSel = 4'h0;
      accRdData = 16'h0000;
      carryFlag = 1'b0;
      mismatches = 0;
      num_checks = 0;
      lfsrState = 16'h003B;   // Seed is 59
      op = 0;
      encTab[0] = `ARU_ENC_RLP;
      encTab[1] = `ARU_ENC_RLC;
      encTab[2] = `ARU_ENC_RRP;
      encTab[3] = `ARU_ENC_RRC;
      encTab[4] = 16'h8A4B;   // Near miss, must be ignored
      for (k = 0; k < 16; k = k + 1)
      begin
         lfsrState = lfsr_next(lfsrState);
         modelAcc[k] = lfsrState;
         stageAcc[k] = lfsrState;
      end
      modelAcc[0] = 16'hA345;
      stageAcc[0] = 16'hA345;
      // Zero-flag source in slot 1
      modelAcc[1] = 16'h0000;
      stageAcc[1] = 16'h0000;
      modelC = 1'b1;
      stageC = 1'b1;
      {expEn, expCz, expC, expS, expZ, expData, expSel} = 0;
      repeat (4) @(posedge mclk);
      check("rstOut", 23'h0, {accWrEn, carryWrEn, signWrEn, zeroWrEn, execDone, accWrData});
      #1 rst_n = 1'b1;
      for (i = 0; i < 602; i = i + 1)
      begin
         @(posedge mclk);
         #1;
         check("enables", {expEn, expEn, expEn, expCz, expCz},
            {accWrEn, execDone, signWrEn, carryWrEn, zeroWrEn});
         check("data", {expSel, expC, expS, expZ, expData},
            {accWrSel, carryWrData, signWrData, zeroWrData, accWrData});
         for (k = 0; k < 16; k = k + 1)
         begin
            fileAcc[k] = stageAcc[k];
            stageAcc[k] = modelAcc[k];
         end
         fileC = stageC;
         stageC = modelC;
         lfsrState = lfsr_next(lfsrState);
         op = (i < 2) ? 1 : lfsrState[6:4] % 5;
         instrValid = (i < 2) || (!lfsrState[7] && i < 600);
         accSel = (i < 2) ? 4'h0 : (lfsrState[15] ? lfsrState[3:0] : {2'b00, lfsrState[9:8]});
         instrWord = encTab[op];
         accRdData = fileAcc[accSel];
         carryFlag = fileC;
         expEn = instrValid && op < 4;
         expCz = expEn && op[0];
         if (expEn)
         begin
            aOld = modelAcc[accSel];
            case (op)
               0: {rNew, cNew} = {aOld[14:0], aOld[15], modelC};
               1: {rNew, cNew} = {aOld[14:0], modelC, aOld[15]};
               2: {rNew, cNew} = {aOld[0], aOld[15:1], modelC};
               default: {rNew, cNew} = {modelC, aOld[15:1], aOld[0]};
            endcase
            modelAcc[accSel] = rNew;
            expData = rNew;
            expSel = accSel;
            expS = rNew[15];
            if (expCz)
            begin
               modelC = cNew;
               expC = cNew;
               expZ = (rNew == 16'h0000);
            end
         end
      end
      final_report;
   end
endmodule // aru_rotate_unit_tb

bind aru_rotate_unit aru_rotate_unit_properties u_props (.mclk(mclk), .rst_n(rst_n),
   .instrValid(instrValid), .instrWord(instrWord), .accSel(accSel), .accRdData(accRdData),
   .carryFlag(carryFlag), .accWrEn(accWrEn), .accWrSel(accWrSel), .accWrData(accWrData),
   .carryWrEn(carryWrEn), .carryWrData(carryWrData), .signWrEn(signWrEn),
   .signWrData(signWrData), .zeroWrEn(zeroWrEn), .zeroWrData(zeroWrData), .execDone(execDone));
